/* File: logic/regulator_ctrl_pkg.sv */
`default_nettype none

package regulator_ctrl_pkg;

  localparam int NUM_CHAN = 3;

  // register offsets
  localparam logic [7:0] ADDR_CHAN_EN   = 8'hd1;
  localparam logic [7:0] ADDR_TRIGGER   = 8'hd2;
  localparam logic [7:0] ADDR_MODE1     = 8'hd3;
  localparam logic [7:0] ADDR_MODE2     = 8'hd4;
  localparam logic [7:0] ADDR_VCODE_1   = 8'hd8;

  // writable bits of the channel-enable and mode registers
  localparam logic [7:0] CHAN_EN_MASK   = 8'h07;
  localparam logic [7:0] MODE1_MASK     = 8'h13;
  localparam logic [7:0] MODE2_MASK     = 8'hf7;

  // field positions
  localparam int CHAN_EN_LSB            = 0;
  localparam int TRIGGER_LSB            = 0;
  localparam int MODE1_SRC_LSB          = 0;
  localparam int MODE1_DEFER_BIT        = 4;
  localparam int MODE2_DSCG_LSB         = 0;
  localparam int MODE2_PSM_LSB          = 4;
  localparam int MODE2_BLANK_BIT        = 7;

  // reset values
  localparam logic [7:0] CHAN_EN_RESET  = 8'h00;
  localparam logic [7:0] MODE1_RESET    = 8'h00;
  localparam logic [7:0] MODE2_RESET    = 8'h07;

  // timing
  localparam int CLOCK_PERIOD_NS        = 10;
  localparam int TSET_NS                = 2600000;
  localparam int TSET_CYCLES            = (TSET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DELAY_CODE_W           = 3;

  typedef enum logic [1:0] {
    SRC_PIN = 2'h0,
    SRC_SW  = 2'h1,
    SRC_AND = 2'h2,
    SRC_OR  = 2'h3
  } en_source_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

endpackage : regulator_ctrl_pkg

`default_nettype wire

/* File: logic/regulator_channel_control_regs.sv */
`default_nettype none

module regulator_channel_control_regs #(
  parameter int TSET_CYCLES = regulator_ctrl_pkg::TSET_CYCLES
) (
  // clock and reset
  input  wire logic                                      clock,
  input  wire logic                                      nrst,
  // register access from the management interface
  input  wire regulator_ctrl_pkg::reg_req_t              req,
  output logic [7:0]                                     rd_data,
  // pins
  input  wire logic [regulator_ctrl_pkg::NUM_CHAN-1:0]   hw_enable_pin,
  input  wire logic                                      sync_mode_pin,
  // delay codes held by the delay registers
  input  wire logic [regulator_ctrl_pkg::NUM_CHAN-1:0][regulator_ctrl_pkg::DELAY_CODE_W-1:0]
                                                         enable_delay_code,
  // to the regulator channels
  output logic [regulator_ctrl_pkg::NUM_CHAN-1:0]        chan_enable,
  output logic [regulator_ctrl_pkg::NUM_CHAN-1:0]        voltage_transition_start,
  output logic [regulator_ctrl_pkg::NUM_CHAN-1:0]        power_save_active,
  output logic [regulator_ctrl_pkg::NUM_CHAN-1:0]        discharge_enable,
  output logic                                           overcurrent_blank_enable
);

  localparam int NC = regulator_ctrl_pkg::NUM_CHAN;
  localparam int TW = (TSET_CYCLES > 1) ? $clog2(TSET_CYCLES) : 1;

  // a zero-length base interval would never let the delay counter wrap
  if (TSET_CYCLES < 1)
  begin : g_bad_tset
    $error("TSET_CYCLES must be at least one");
  end

  // the mode register fields leave room for three channels only
  if (regulator_ctrl_pkg::MODE2_PSM_LSB + NC > regulator_ctrl_pkg::MODE2_BLANK_BIT)
  begin : g_bad_chan
    $error("channel count does not fit the mode register fields");
  end

  logic [NC-1:0] chan_sw_enable_r;
  logic          deferred_scaling_mode_r;
  logic [1:0]    en_source_r;
  logic          overcurrent_blank_r;
  logic [NC-1:0] power_save_select_r;
  logic [NC-1:0] discharge_r;
  logic [NC-1:0] resolved_en;
  logic [NC-1:0] transition_nxt;
  logic [7:0]    rd_data_nxt;

  wire wr_chan_en = req.wr && (req.addr == regulator_ctrl_pkg::ADDR_CHAN_EN);
  wire wr_trigger = req.wr && (req.addr == regulator_ctrl_pkg::ADDR_TRIGGER);
  wire wr_mode1   = req.wr && (req.addr == regulator_ctrl_pkg::ADDR_MODE1);
  wire wr_mode2   = req.wr && (req.addr == regulator_ctrl_pkg::ADDR_MODE2);

  // channel software enables
  always_ff @(posedge clock)
  begin
    if (!nrst)
      chan_sw_enable_r <= regulator_ctrl_pkg::CHAN_EN_RESET[NC-1:0];
    else if (wr_chan_en)
      chan_sw_enable_r <= req.data[regulator_ctrl_pkg::CHAN_EN_LSB +: NC];
  end

  // mode register one
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      deferred_scaling_mode_r <= regulator_ctrl_pkg::MODE1_RESET[regulator_ctrl_pkg::MODE1_DEFER_BIT];
      en_source_r             <= regulator_ctrl_pkg::MODE1_RESET[regulator_ctrl_pkg::MODE1_SRC_LSB +: 2];
    end
    else if (wr_mode1)
    begin
      deferred_scaling_mode_r <= req.data[regulator_ctrl_pkg::MODE1_DEFER_BIT];
      en_source_r             <= req.data[regulator_ctrl_pkg::MODE1_SRC_LSB +: 2];
    end
  end

  // mode register two
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      overcurrent_blank_r <= regulator_ctrl_pkg::MODE2_RESET[regulator_ctrl_pkg::MODE2_BLANK_BIT];
      power_save_select_r <= regulator_ctrl_pkg::MODE2_RESET[regulator_ctrl_pkg::MODE2_PSM_LSB +: NC];
      discharge_r         <= regulator_ctrl_pkg::MODE2_RESET[regulator_ctrl_pkg::MODE2_DSCG_LSB +: NC];
    end
    else if (wr_mode2)
    begin
      overcurrent_blank_r <= req.data[regulator_ctrl_pkg::MODE2_BLANK_BIT];
      power_save_select_r <= req.data[regulator_ctrl_pkg::MODE2_PSM_LSB +: NC];
      discharge_r         <= req.data[regulator_ctrl_pkg::MODE2_DSCG_LSB +: NC];
    end
  end

  // transition start: trigger bits are never stored, only pulsed
  always_comb
  begin
    transition_nxt = '0;
    for (int i = 0; i < NC; i++)
    begin
      if (deferred_scaling_mode_r)
        transition_nxt[i] = wr_trigger && req.data[regulator_ctrl_pkg::TRIGGER_LSB + i];
      else
        // the code register write itself is the trigger here
        transition_nxt[i] = req.wr &&
          (req.addr == regulator_ctrl_pkg::ADDR_VCODE_1 + 8'(i));
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      voltage_transition_start <= '0;
    else
      voltage_transition_start <= transition_nxt;
  end

  // enable source resolution
  always_comb
  begin
    case (regulator_ctrl_pkg::en_source_t'(en_source_r))
      regulator_ctrl_pkg::SRC_PIN: resolved_en = hw_enable_pin;
      regulator_ctrl_pkg::SRC_SW:  resolved_en = chan_sw_enable_r;
      regulator_ctrl_pkg::SRC_AND: resolved_en = hw_enable_pin & chan_sw_enable_r;
      regulator_ctrl_pkg::SRC_OR:  resolved_en = hw_enable_pin | chan_sw_enable_r;
      default:                     resolved_en = hw_enable_pin;
    endcase
  end

  // per-channel enable delay; disable takes effect at once
  for (genvar g = 0; g < NC; g++)
  begin : g_delay
    logic [TW-1:0]                               tick_r;
    logic [regulator_ctrl_pkg::DELAY_CODE_W-1:0] mult_r;

    always_ff @(posedge clock)
    begin
      if (!nrst || !resolved_en[g] || chan_enable[g])
      begin
        tick_r <= '0;
        mult_r <= '0;
      end
      else if (tick_r == TW'(TSET_CYCLES - 1))
      begin
        tick_r <= '0;
        mult_r <= mult_r + 1'b1;
      end
      else
        tick_r <= tick_r + 1'b1;
    end

    always_ff @(posedge clock)
    begin
      if (!nrst || !resolved_en[g])
        chan_enable[g] <= 1'b0;
      else if (mult_r == enable_delay_code[g])
        chan_enable[g] <= 1'b1;
    end
  end

  // mode pin low overrides power-save select
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      power_save_active        <= '0;
      discharge_enable         <= regulator_ctrl_pkg::MODE2_RESET[regulator_ctrl_pkg::MODE2_DSCG_LSB +: NC];
      overcurrent_blank_enable <= 1'b0;
    end
    else
    begin
      power_save_active        <= power_save_select_r & {NC{sync_mode_pin}};
      discharge_enable         <= discharge_r;
      overcurrent_blank_enable <= overcurrent_blank_r;
    end
  end

  // read path; trigger register and unmapped offsets read zero
  always_comb
  begin
    rd_data_nxt = 8'h00;
    case (req.addr)
      regulator_ctrl_pkg::ADDR_CHAN_EN:
      begin
        rd_data_nxt[regulator_ctrl_pkg::CHAN_EN_LSB +: NC] = chan_sw_enable_r;
        rd_data_nxt = rd_data_nxt & regulator_ctrl_pkg::CHAN_EN_MASK;
      end
      regulator_ctrl_pkg::ADDR_MODE1:
      begin
        rd_data_nxt[regulator_ctrl_pkg::MODE1_DEFER_BIT]    = deferred_scaling_mode_r;
        rd_data_nxt[regulator_ctrl_pkg::MODE1_SRC_LSB +: 2] = en_source_r;
        rd_data_nxt = rd_data_nxt & regulator_ctrl_pkg::MODE1_MASK;
      end
      regulator_ctrl_pkg::ADDR_MODE2:
      begin
        rd_data_nxt[regulator_ctrl_pkg::MODE2_BLANK_BIT]      = overcurrent_blank_r;
        rd_data_nxt[regulator_ctrl_pkg::MODE2_PSM_LSB +: NC]  = power_save_select_r;
        rd_data_nxt[regulator_ctrl_pkg::MODE2_DSCG_LSB +: NC] = discharge_r;
        rd_data_nxt = rd_data_nxt & regulator_ctrl_pkg::MODE2_MASK;
      end
      regulator_ctrl_pkg::ADDR_TRIGGER:
        rd_data_nxt = 8'h00;
      default:
        rd_data_nxt = 8'h00;
    endcase
  end

  // registered so the host sees a stable byte until its next read
  always_ff @(posedge clock)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (req.rd)
      rd_data <= rd_data_nxt;
  end

endmodule // regulator_channel_control_regs

`default_nettype wire

/* File: sim/regulator_ctrl_asserts.sv */
`default_nettype none
module ctrl_asserts (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         nrst,
  // watched ports
  input wire regulator_ctrl_pkg::reg_req_t req,
  input wire logic [2:0]                   hw_enable_pin,
  input wire logic                         sync_mode_pin,
  input wire logic [2:0]                   chan_enable,
  input wire logic [2:0]                   voltage_transition_start,
  input wire logic [2:0]                   power_save_active,
  input wire logic [2:0]                   discharge_enable,
  input wire logic                         overcurrent_blank_enable
);
  timeunit 1ns / 1ps;
  // shadow copies, updated on the same edge as the design's registers
  logic       defer_r;
  logic [1:0] src_r;
  logic [2:0] sw_r;
  logic [2:0] res;
  wire logic [2:0] vts = voltage_transition_start;
  wire logic w_trig = req.wr && req.addr == 8'hd2;
  wire logic w_code = req.wr && req.addr inside {8'hd8, 8'hd9, 8'hda};
  wire logic w_mode2 = req.wr && req.addr == 8'hd4;
  always_ff @(posedge clock)
    if (!nrst) {defer_r, src_r, sw_r} <= 6'h0;
    else if (req.wr && req.addr == 8'hd3) {defer_r, src_r} <= {req.data[4], req.data[1:0]};
    else if (req.wr && req.addr == 8'hd1) sw_r <= req.data[2:0];
  always_comb
    case (src_r)
      2'h0: res = hw_enable_pin;
      2'h1: res = sw_r;
      2'h2: res = hw_enable_pin & sw_r;
      default: res = hw_enable_pin | sw_r;
    endcase
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_defer_go:
    assert property (w_trig && defer_r |=> vts == $past(req.data[2:0])) else $error("go");
  chk_go_ignored:
    assert property (w_trig && !defer_r |=> vts == 3'h0) else $error("go ignored");
  chk_pulse_once:
    assert property (!req.wr |=> vts == 3'h0) else $error("stray pulse");
  chk_code_start:
    assert property (w_code && !defer_r |=> vts == 3'h1 << $past(req.addr[1:0]))
      else $error("code start");
  chk_blank_copy:
    assert property (w_mode2 |=> ##1 overcurrent_blank_enable == $past(req.data[7], 2))
      else $error("blank");
  chk_discharge_copy:
    assert property (w_mode2 |=> ##1 discharge_enable == $past(req.data[2:0], 2))
      else $error("discharge");
  chk_mode_pin_low:
    assert property (!sync_mode_pin |=> power_save_active == 3'h0) else $error("psm");
  chk_resolved_enable:
    assert property (1'b1 |=> (chan_enable & ~$past(res)) == 3'h0) else $error("enable");
  cover property (vts != 3'h0);
  cover property (chan_enable != 3'h0);
  cover property (power_save_active != 3'h0);
endmodule // ctrl_asserts
`default_nettype wire

/* File: sim/mgmt_host.sv */
`default_nettype none
module mgmt_host (
  // bus
  input  wire logic                        clock,
  output var regulator_ctrl_pkg::reg_req_t req,
  input  wire logic [7:0]                  rd_data
);
  timeunit 1ns / 1ps;
  initial req = '0;
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    req <= '{1'b0, 1'b1, a, ~a};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~a, a};
    #1;
    d = rd_data;
  endtask
endmodule // mgmt_host
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic                         clock = 1'b0;
  logic                         nrst = 1'b0;
  logic [2:0]                   en_pin = 3'h0;
  logic                         sync_pin = 1'b1;
  logic [2:0][2:0]              dly = '0;
  regulator_ctrl_pkg::reg_req_t req;
  logic [7:0]                   rd_data, q;
  logic [2:0]                   chan_en, vts, psm, dscg;
  logic                         blank;
  int                           errors = 0;
  int                           num_checks = 0;
  always #5 clock = ~clock;
  mgmt_host host (.clock(clock), .req(req), .rd_data(rd_data));
  regulator_channel_control_regs #(.TSET_CYCLES(4)) uut (
    .clock(clock), .nrst(nrst), .req(req), .rd_data(rd_data), .hw_enable_pin(en_pin),
    .sync_mode_pin(sync_pin), .enable_delay_code(dly), .chan_enable(chan_en),
    .voltage_transition_start(vts), .power_save_active(psm), .discharge_enable(dscg),
    .overcurrent_blank_enable(blank));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q);
    check(q, e);
  endtask
  task automatic go(input logic [7:0] a, input logic [7:0] d, input logic [2:0] e);
    w(1);
    host.wr(a, d);
    #1;
    check(8'(vts), 8'(e));
    w(1);
    check(8'(vts), 8'h00);
  endtask
  task report_and_stop;
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    errors++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rchk(8'hd1, 8'h00);
    rchk(8'hd3, 8'h00);
    rchk(8'hd4, 8'h07);
    check(8'({blank, psm, dscg}), 8'h07);
    host.wr(8'hd1, 8'hff);
    rchk(8'hd1, 8'h07);
    host.wr(8'hd3, 8'hef);
    rchk(8'hd3, 8'h03);
    host.wr(8'hd4, 8'hf8);
    rchk(8'hd4, 8'hf0);
    rchk(8'hd2, 8'h00);
    rchk(8'hee, 8'h00);
    check(8'({blank, psm, dscg}), 8'h78);
    host.wr(8'hd4, 8'h50);
    w(2);
    check(8'({blank, psm, dscg}), 8'h28);
    @(posedge clock);
    sync_pin <= 1'b0;
    w(2);
    check(8'(psm), 8'h00);
    host.wr(8'hd1, 8'h03);
    @(posedge clock);
    en_pin <= 3'h5;
    for (int s = 0; s < 4; s++)
    begin
      host.wr(8'hd3, 8'(s));
      w(3);
      check(8'(chan_en), 8'(s == 0 ? 3'h5 : s == 1 ? 3'h3 : s == 2 ? 3'h1 : 3'h7));
    end
    host.wr(8'hd3, 8'h01);
    host.wr(8'hd1, 8'h00);
    @(posedge clock);
    dly[0] <= 3'h2;
    host.wr(8'hd1, 8'h01);
    w(5);
    check(8'(chan_en), 8'h00);
    w(8);
    check(8'(chan_en), 8'h01);
    go(8'hd2, 8'h07, 3'h0);
    go(8'hd9, 8'h40, 3'h2);
    host.wr(8'hd3, 8'h10);
    go(8'hda, 8'h40, 3'h0);
    go(8'hd2, 8'h05, 3'h5);
    go(8'hd2, 8'h02, 3'h2);
    check(8'(vts), 8'h00);
    report_and_stop;
  end
endmodule // tb
bind regulator_channel_control_regs ctrl_asserts chk (
  .clock(clock), .nrst(nrst), .req(req), .hw_enable_pin(hw_enable_pin),
  .sync_mode_pin(sync_mode_pin), .chan_enable(chan_enable),
  .voltage_transition_start(voltage_transition_start),
  .power_save_active(power_save_active), .discharge_enable(discharge_enable),
  .overcurrent_blank_enable(overcurrent_blank_enable));
`default_nettype wire
